// file: addr_record_store.sv
`timescale 1ns/10ps
`include "err_params.svh"
module addr_record_store #(
  parameter int NREC     = 2,
  parameter int PA_BITS  = `PADDR_W,
  parameter int LOW_BITS = 0,
  parameter bit RME      = 1'b0,
  parameter bit VA_IMPL  = 1'b1,
  parameter bit SI_RW    = 1'b1,
  parameter bit AI_RW    = 1'b1,
  parameter bit VA_RW    = 1'b1
) (
  input  wire logic  clock_i,
  input  wire logic  rst_i,
  input  wire logic  ce_i,
  err_reg_if.addr_mp bus
);
  import err_pkg::*;

  // RL4: flag access kind
  function automatic word_t field_mask(input bit wr);
    word_t m;
    m = '0;
    for (int b = LOW_BITS; b < PA_BITS; b++) begin
      m[b] = 1'b1;
    end
    m[`A_NS]  = 1'b1;
    // RL2: space-unsure flag kept
    m[`A_SI]  = !wr || SI_RW;
    // RL3: address-incorrect flag kept
    m[`A_AI]  = !wr || AI_RW;
    // RL5: virtual flag only if built
    m[`A_VA]  = VA_IMPL && (!wr || VA_RW);
    m[`A_NSE] = RME;
    return m;
  endfunction

  localparam word_t RD_M = field_mask(1'b0);
  localparam word_t WR_M = field_mask(1'b1);

  word_t mem [NREC];
  word_t rd_reg;

  ////////////////////////////////////////////////////////////////////////
  // RL10: cold reset only, kept otherwise
  // Capture beats a software write to the same record
  always_ff @(posedge clock_i) begin
    for (int i = 0; i < NREC; i++) begin
      if (rst_i) begin
        mem[i] <= `ZERO64;
      end else if (ce_i && bus.cap_valid && int'(bus.cap_idx) == i) begin
        mem[i] <= bus.cap_word & RD_M;
      end else if (ce_i && bus.wr_addr && int'(bus.idx) == i) begin
        mem[i] <= (mem[i] & ~WR_M) | (bus.wdata & WR_M);
      end
    end
  end

  // RL9: registered read, absent records zero
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      rd_reg <= `ZERO64;
    end else if (ce_i) begin
      rd_reg <= (int'(bus.idx) < NREC) ? mem[bus.idx] : `ZERO64;
    end
  end

  assign bus.addr_q = rd_reg;

  ////////////////////////////////////////////////////////////////////////
  a_addr_rsv_zero: assert property ( // RL8
    @(posedge clock_i) disable iff (rst_i)
    bus.addr_q[`A_RSV_HI:`A_RSV_LO] == 3'h0 &&
    (RME || !bus.addr_q[`A_NSE]))
    else $error("reserved location bits not zero");
endmodule

// file: ctrl_reg_store.sv
`timescale 1ns/10ps
`include "err_params.svh"
module ctrl_reg_store #(
  parameter err_pkg::feat_t CI_FEAT   = `FEAT_BOTH,
  parameter err_pkg::feat_t DUI_FEAT  = `FEAT_SPLIT,
  parameter err_pkg::feat_t CFI_FEAT  = `FEAT_SPLIT,
  parameter logic [31:0]    IMPDEF_HI = 32'h0
) (
  input  wire logic  clock_i,
  input  wire logic  rst_i,
  input  wire logic  ce_i,
  err_reg_if.ctrl_mp bus
);
  import err_pkg::*;

  // RL12: absent features hold zero
  function automatic logic [31:0] ctrl_mask();
    logic [31:0] m;
    m = '0;
    m[`C_CI]   = CI_FEAT == `FEAT_BOTH;
    m[`C_DEFERRED_WRITE_IRQ_EN] = DUI_FEAT == `FEAT_SPLIT;
    m[`C_DUI]  = DUI_FEAT == `FEAT_BOTH || DUI_FEAT == `FEAT_SPLIT;
    m[`C_CORR_WRITE_FAULT_IRQ_EN] = CFI_FEAT == `FEAT_SPLIT;
    m[`C_CFI]  = CFI_FEAT == `FEAT_BOTH || CFI_FEAT == `FEAT_SPLIT;
    return m;
  endfunction

  localparam logic [31:0] M = ctrl_mask();

  logic [31:0] lo_reg;

  ////////////////////////////////////////////////////////////////////////
  // RL10: cold reset only
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      lo_reg <= 32'h0;
    end else if (ce_i && bus.wr_ctrl) begin
      lo_reg <= bus.wdata[`C_LO_W-1:0] & M;
    end
  end

  // RL14: upper half fixed, writes dropped
  assign bus.ctrl_q = {IMPDEF_HI, lo_reg};

  a_ctrl_rsv_zero: assert property ( // RL14
    @(posedge clock_i) disable iff (rst_i)
    bus.ctrl_q[`C_RSV_HI:`C_RSV_LO] == 18'h0 && !bus.ctrl_q[`C_RSV12])
    else $error("reserved control bits not zero");
endmodule

// file: err_params.svh
`ifndef ERR_PARAMS_SVH
`define ERR_PARAMS_SVH
// Register offsets inside one record window
`define CTRL_OFS  6'h08
`define ADDR_OFS  6'h18
`define REC_SHIFT 6
`define OFS_W     6
// Location register field positions
`define A_NS      63
`define A_SI      62
`define A_AI      61
`define A_VA      60
`define A_NSE     59
`define A_RSV_HI  58
`define A_RSV_LO  56
`define PADDR_W   56
// Control register field positions
`define C_CI      13
`define C_RSV12   12
`define C_RSV_HI  31
`define C_RSV_LO  14
`define C_DEFERRED_WRITE_IRQ_EN    11
`define C_DUI     10
`define C_CORR_WRITE_FAULT_IRQ_EN    9
`define C_CFI     8
`define C_LO_W    32
// Feature codes
`define FEAT_BOTH  2'h2
`define FEAT_SPLIT 2'h3
// Space bits {ns, unsure, incorrect} for a virtual address
`define VA_SPACE  3'h3
`define ZERO64    64'h0
`endif

// file: err_pkg.sv
package err_pkg;
  typedef logic [63:0] word_t;
  typedef logic [1:0]  feat_t;
  typedef enum logic [1:0] {REG_NONE, REG_CTRL, REG_ADDR} reg_kind_t;
endpackage

// file: err_reg_if.sv
`timescale 1ns/10ps
interface err_reg_if #(parameter int REC_W = 1);
  import err_pkg::*;
  logic             wr_ctrl;
  logic             wr_addr;
  logic [REC_W-1:0] idx;
  word_t            wdata;
  logic             cap_valid;
  logic [REC_W-1:0] cap_idx;
  word_t            cap_word;
  word_t            ctrl_q;
  word_t            addr_q;
  modport top (output wr_ctrl, wr_addr, idx, wdata, cap_valid, cap_idx,
               cap_word, input ctrl_q, addr_q);
  modport addr_mp (input wr_addr, idx, wdata, cap_valid, cap_idx,
                   cap_word, output addr_q);
  modport ctrl_mp (input wr_ctrl, wdata, output ctrl_q);
endinterface

// file: error_record_addr_ctrl.sv
`timescale 1ns/10ps
`include "err_params.svh"
// Overview of operation
// RL1: Without realm option, space bit 0 means Secure, 1 Non-secure.
// RL2: Space-unsure flag 1 when space bit may be wrong, else 0.
// RL3: Bit 61 is 1 when the recorded address may be invalid.
// RL4: Unsure, incorrect and virtual flags each read-only or writable.
// RL5: Bit 60 is 1 when a context-free virtual address is held.
// RL6: Virtual address capture records space bits 0,1,1 and realm bit 0.
// RL7: Without virtual flag, virtual capture still reads space bits 0,1,1.
// RL8: Bit 59 used only with realm option; bits 58:56 read zero.
// RL9: Bits 55:0 hold location; unimplemented high or low bits zero.
// RL10: Fields cleared by cold reset only, kept across recovery reset.
// RL11: Location writes dropped while address-valid set, unless injection.
// RL12: Control exists in first record only; absent features read zero.
// RL13: Control is 64-bit at 0x008 plus 64 per record, or by select.
// RL14: Control bits 63:32 fixed, 31:14 and 12 read zero.
// RL15: Critical enable raises critical irq; else treated as uncontained.
// RL16: Split deferred code: bit 11 enables recovery irq on writes.
// RL17: Bit 10 covers deferred reads and writes, or reads only if split.
// RL18: Enabled irq raised even when the syndrome is dropped.
// RL19: Split corrected code: bit 9 enables fault irq on writes.
// RL20: Corrected event is a counter overflow setting its flag.
// RL21: No corrected event from flag writes or repeat overflows.
// RL22: Both-ways corrected code: bit 8 enables fault irq for all.
// RL23: Irq outputs stay high until software clears their cause.
module error_record_addr_ctrl #(
  parameter int             NREC      = 2,
  parameter int             REC_W     = 1,
  parameter int             PA_BITS   = `PADDR_W,
  parameter int             LOW_BITS  = 0,
  parameter bit             RME       = 1'b0,
  parameter bit             VA_IMPL   = 1'b1,
  parameter bit             SI_RW     = 1'b1,
  parameter bit             AI_RW     = 1'b1,
  parameter bit             VA_RW     = 1'b1,
  parameter bit             FI_IMPL   = 1'b0,
  parameter err_pkg::feat_t CI_FEAT   = `FEAT_BOTH,
  parameter err_pkg::feat_t DUI_FEAT  = `FEAT_SPLIT,
  parameter err_pkg::feat_t CFI_FEAT  = `FEAT_SPLIT,
  parameter logic [31:0]    IMPDEF_HI = 32'h0
) (
  input  wire logic                          clock_i,
  input  wire logic                          rst_i,
  input  wire logic                          ce_i,
  input  wire logic                          mm_req_i,
  input  wire logic                          mm_write_i,
  input  wire logic [REC_W+`REC_SHIFT-1:0]   mm_addr_i,
  input  wire err_pkg::word_t                mm_wdata_i,
  output logic                               mm_ack_o,
  input  wire logic                          sel_write_i,
  input  wire logic [REC_W-1:0]              sel_value_i,
  output logic      [REC_W-1:0]              sel_value_o,
  input  wire logic                          sys_req_i,
  input  wire logic                          sys_write_i,
  input  wire err_pkg::reg_kind_t            sys_kind_i,
  input  wire err_pkg::word_t                sys_wdata_i,
  output logic                               sys_ack_o,
  output err_pkg::word_t                     rdata_o,
  input  wire logic                          cap_valid_i,
  input  wire logic [REC_W-1:0]              cap_idx_i,
  input  wire logic [`PADDR_W-1:0]           cap_paddr_i,
  input  wire logic                          cap_ns_i,
  input  wire logic                          cap_nse_i,
  input  wire logic                          cap_unsure_i,
  input  wire logic                          cap_incorrect_i,
  input  wire logic                          cap_va_i,
  input  wire logic [NREC-1:0]               status_av_i,
  input  wire logic                          inj_av_i,
  input  wire logic                          evt_write_i,
  input  wire logic                          evt_critical_i,
  input  wire logic                          evt_deferred_i,
  input  wire logic                          cnt_overflow_i,
  input  wire logic                          ovf_flag_was_i,
  input  wire logic                          clr_crit_i,
  input  wire logic                          clr_recov_i,
  input  wire logic                          clr_fault_i,
  output logic                               crit_irq_o,
  output logic                               uncontained_o,
  output logic                               recov_irq_o,
  output logic                               fault_irq_o
);
  import err_pkg::*;

  err_reg_if #(.REC_W(REC_W)) bus ();

  ////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic sticky(input logic q, input logic set,
                                  input logic clr);
    // Set wins so an event in the clearing cycle survives
    return set | (q & ~clr);
  endfunction

  function automatic logic in_range(input logic [REC_W-1:0] rec);
    return int'(rec) < NREC;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Storage
  addr_record_store #(
    .NREC     (NREC),
    .PA_BITS  (PA_BITS),
    .LOW_BITS (LOW_BITS),
    .RME      (RME),
    .VA_IMPL  (VA_IMPL),
    .SI_RW    (SI_RW),
    .AI_RW    (AI_RW),
    .VA_RW    (VA_RW)
  ) u_addr (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .ce_i    (ce_i),
    .bus     (bus)
  );

  ctrl_reg_store #(
    .CI_FEAT   (CI_FEAT),
    .DUI_FEAT  (DUI_FEAT),
    .CFI_FEAT  (CFI_FEAT),
    .IMPDEF_HI (IMPDEF_HI)
  ) u_ctrl (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .ce_i    (ce_i),
    .bus     (bus)
  );

  ////////////////////////////////////////////////////////////////////////
  // Memory-mapped decode
  logic [REC_W-1:0]  mm_rec;
  logic [`OFS_W-1:0] mm_ofs;
  reg_kind_t         mm_kind;

  // RL13: record stride and control offset
  assign mm_rec  = mm_addr_i[REC_W+`REC_SHIFT-1:`REC_SHIFT];
  assign mm_ofs  = mm_addr_i[`OFS_W-1:0];
  assign mm_kind = (mm_ofs == `CTRL_OFS) ? REG_CTRL :
                   (mm_ofs == `ADDR_OFS) ? REG_ADDR : REG_NONE;

  // RL13: system view selects a record by index
  logic [REC_W-1:0] record_select_reg;

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      record_select_reg <= '0;
    end else if (ce_i && sel_write_i) begin
      record_select_reg <= sel_value_i;
    end
  end

  assign sel_value_o = record_select_reg;

  ////////////////////////////////////////////////////////////////////////
  // Access merge; the mapped view wins a same-cycle clash
  logic             mm_take;
  logic             sys_take;
  logic             acc_take;
  logic             acc_write;
  logic [REC_W-1:0] acc_rec;
  reg_kind_t        acc_kind;
  logic             rec_ok;
  logic             rec_first;
  logic             lock;

  assign mm_take   = mm_req_i;
  assign sys_take  = sys_req_i & ~mm_req_i;
  assign acc_take  = mm_take | sys_take;
  assign acc_write = mm_take ? mm_write_i : sys_write_i;
  assign acc_rec   = mm_take ? mm_rec : record_select_reg;
  assign acc_kind  = mm_take ? mm_kind : sys_kind_i;
  assign rec_ok    = in_range(acc_rec);
  assign rec_first = acc_rec == '0;

  // RL11: address-valid locks the location
  assign lock = rec_ok && status_av_i[acc_rec] && (!FI_IMPL || !inj_av_i);

  // RL12: control only in the first record
  assign bus.wr_ctrl = acc_take && acc_write && acc_kind == REG_CTRL &&
                       rec_first;
  assign bus.wr_addr = acc_take && acc_write && acc_kind == REG_ADDR &&
                       rec_ok && !lock;
  assign bus.idx     = acc_rec;
  assign bus.wdata   = mm_take ? mm_wdata_i : sys_wdata_i;

  ////////////////////////////////////////////////////////////////////////
  // Capture of a new error location
  // RL6: virtual address forces the space bits
  // RL7: same pattern when the virtual flag is absent
  // RL1: space bit stored as reported
  assign bus.cap_valid = cap_valid_i;
  assign bus.cap_idx   = cap_idx_i;
  assign bus.cap_word  = cap_va_i ?
    {`VA_SPACE, VA_IMPL, 1'b0, 3'h0, cap_paddr_i} :
    {cap_ns_i, cap_unsure_i, cap_incorrect_i, 1'b0, cap_nse_i & RME,
     3'h0, cap_paddr_i};

  ////////////////////////////////////////////////////////////////////////
  // Read pipeline: stage one waits for the stored word
  logic      p_valid_reg;
  logic      p_mm_reg;
  logic      p_read_reg;
  reg_kind_t p_kind_reg;
  logic      p_first_reg;
  logic      p_ok_reg;
  word_t     rdata_next;
  logic      mm_ack_reg;
  logic      sys_ack_reg;
  word_t     rdata_reg;

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      p_valid_reg <= 1'b0;
      p_mm_reg    <= 1'b0;
      p_read_reg  <= 1'b0;
      p_kind_reg  <= REG_NONE;
      p_first_reg <= 1'b0;
      p_ok_reg    <= 1'b0;
    end else if (ce_i) begin
      p_valid_reg <= acc_take;
      p_mm_reg    <= mm_take;
      p_read_reg  <= !acc_write;
      p_kind_reg  <= acc_kind;
      p_first_reg <= rec_first;
      p_ok_reg    <= rec_ok;
    end
  end

  // Unmapped offsets and absent records read zero
  assign rdata_next =
    !p_read_reg ? `ZERO64 :
    (p_kind_reg == REG_CTRL && p_first_reg) ? bus.ctrl_q :
    (p_kind_reg == REG_ADDR && p_ok_reg) ? bus.addr_q : `ZERO64;

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      mm_ack_reg  <= 1'b0;
      sys_ack_reg <= 1'b0;
      rdata_reg   <= `ZERO64;
    end else if (ce_i) begin
      mm_ack_reg  <= p_valid_reg & p_mm_reg;
      sys_ack_reg <= p_valid_reg & ~p_mm_reg;
      rdata_reg   <= p_valid_reg ? rdata_next : rdata_reg;
    end
  end

  assign mm_ack_o  = mm_ack_reg;
  assign sys_ack_o = sys_ack_reg;
  assign rdata_o   = rdata_reg;

  ////////////////////////////////////////////////////////////////////////
  // Interrupt qualification
  logic ci_en;
  logic dui_en;
  logic deferred_write_irq_en_en;
  logic cfi_en;
  logic corr_write_fault_irq_en_en;
  logic dui_both;
  logic cfi_both;
  logic corr_evt;
  logic crit_set;
  logic unc_set;
  logic recov_set;
  logic fault_set;

  assign ci_en    = bus.ctrl_q[`C_CI];
  assign dui_en   = bus.ctrl_q[`C_DUI];
  assign deferred_write_irq_en_en  = bus.ctrl_q[`C_DEFERRED_WRITE_IRQ_EN];
  assign cfi_en   = bus.ctrl_q[`C_CFI];
  assign corr_write_fault_irq_en_en  = bus.ctrl_q[`C_CORR_WRITE_FAULT_IRQ_EN];
  assign dui_both = DUI_FEAT == `FEAT_BOTH;
  assign cfi_both = CFI_FEAT == `FEAT_BOTH;

  // RL15: critical path or uncontained fallback
  assign crit_set = evt_critical_i & ci_en;
  assign unc_set  = evt_critical_i & ~ci_en;

  // RL16: write side of deferred errors
  // RL17: read side, or both ways
  // RL18: dropped syndromes still count, no gating term
  assign recov_set = evt_deferred_i &
                     ((dui_en & (dui_both | ~evt_write_i)) |
                      (deferred_write_irq_en_en & evt_write_i));

  // RL20: only a fresh overflow is an event
  // RL21: an already-set flag gives no event
  assign corr_evt = cnt_overflow_i & ~ovf_flag_was_i;

  // RL19: write side of corrected events
  // RL22: bit 8 covers both ways
  assign fault_set = corr_evt &
                     ((cfi_en & (cfi_both | ~evt_write_i)) |
                      (corr_write_fault_irq_en_en & evt_write_i));

  // RL23: held until software clears the cause
  logic crit_reg;
  logic unc_reg;
  logic recov_reg;
  logic fault_reg;

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      crit_reg  <= 1'b0;
      unc_reg   <= 1'b0;
      recov_reg <= 1'b0;
      fault_reg <= 1'b0;
    end else if (ce_i) begin
      crit_reg  <= sticky(crit_reg, crit_set, clr_crit_i);
      unc_reg   <= sticky(unc_reg, unc_set, clr_crit_i);
      recov_reg <= sticky(recov_reg, recov_set, clr_recov_i);
      fault_reg <= sticky(fault_reg, fault_set, clr_fault_i);
    end
  end

  assign crit_irq_o    = crit_reg;
  assign uncontained_o = unc_reg;
  assign recov_irq_o   = recov_reg;
  assign fault_irq_o   = fault_reg;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (rst_i);

  a_crit_irq_set: assert property ( // RL15
    evt_critical_i && ce_i && ci_en |=> crit_irq_o && !$past(unc_set))
    else $error("critical irq not raised");

  a_unc_fallback: assert property ( // RL15
    evt_critical_i && ce_i && !ci_en |=> uncontained_o)
    else $error("critical error not treated as uncontained");

  a_recov_write: assert property ( // RL16
    evt_deferred_i && evt_write_i && deferred_write_irq_en_en && ce_i |=> recov_irq_o)
    else $error("deferred write irq missing");

  a_recov_read: assert property ( // RL17
    evt_deferred_i && !evt_write_i && dui_en && ce_i |=> recov_irq_o)
    else $error("deferred read irq missing");

  a_recov_split_wr: assert property ( // RL17
    !dui_both && evt_deferred_i && evt_write_i && !deferred_write_irq_en_en && ce_i &&
    !recov_irq_o |=> !recov_irq_o)
    else $error("bit 10 wrongly covers writes");

  a_fault_write: assert property ( // RL19
    cnt_overflow_i && !ovf_flag_was_i && evt_write_i && corr_write_fault_irq_en_en && ce_i
    |=> fault_irq_o)
    else $error("corrected write irq missing");

  a_fault_both: assert property ( // RL22
    corr_evt && cfi_en && (cfi_both || !evt_write_i) && ce_i |=> fault_irq_o)
    else $error("corrected irq missing");

  a_no_repeat_evt: assert property ( // RL21
    !fault_irq_o && ovf_flag_was_i && ce_i |=> !fault_irq_o)
    else $error("fault irq from stale overflow");

  a_irq_hold: assert property ( // RL23
    crit_irq_o && !clr_crit_i && ce_i |=> crit_irq_o)
    else $error("critical irq dropped without clear");

  a_addr_lock: assert property ( // RL11
    mm_req_i && mm_write_i && mm_kind == REG_ADDR && lock |-> !bus.wr_addr)
    else $error("locked location written");

  a_ctrl_first: assert property ( // RL12
    mm_req_i && !mm_write_i && mm_kind == REG_CTRL && mm_rec != '0 &&
    ce_i ##1 ce_i |=> mm_ack_o && rdata_o == `ZERO64)
    else $error("control visible outside first record");

  a_va_space: assert property ( // RL6
    cap_valid_i && cap_va_i |->
    bus.cap_word[`A_NS:`A_AI] == `VA_SPACE && !bus.cap_word[`A_NSE])
    else $error("virtual capture space bits wrong");

  c_crit_irq: cover property (crit_irq_o && clr_crit_i);
  c_lock_hit: cover property (acc_take && acc_write && lock);
  c_va_cap: cover property (cap_valid_i && cap_va_i && ce_i);
  c_sys_read: cover property (sys_take && !sys_write_i ##2 sys_ack_o);
endmodule

// file: error_record_addr_ctrl_bench.sv
`timescale 1ns/10ps
`include "err_params.svh"
module error_record_addr_ctrl_bench;
  import err_pkg::*;
  `define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin \
    mismatches++; \
    $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end
  ////////////////////////////////////////////////////////////////////////////
  logic        clock_i, rst_i, ce_i, mm_req_i, mm_write_i, mm_ack_o;
  logic        sel_write_i, sys_req_i, sys_write_i, sys_ack_o, cap_valid_i;
  logic        cap_ns_i, cap_nse_i, cap_unsure_i, cap_incorrect_i, cap_va_i;
  logic        inj_av_i, evt_write_i, evt_critical_i, evt_deferred_i;
  logic        cnt_overflow_i, ovf_flag_was_i, clr_crit_i, clr_recov_i;
  logic        clr_fault_i, crit_irq_o, uncontained_o, recov_irq_o;
  logic        fault_irq_o;
  logic [3:0]  irq_v;
  logic [6:0]  mm_addr_i;
  logic [0:0]  sel_value_i, sel_value_o, cap_idx_i;
  logic [55:0] cap_paddr_i;
  logic [1:0]  status_av_i;
  reg_kind_t   sys_kind_i;
  word_t       mm_wdata_i, sys_wdata_i, rdata_o, exp_w, d, amask;
  word_t       exp_q[$];
  logic [31:0] seed = 32'h9A94;
  int          mismatches = 0;
  int          check_count = 0;
  // Event {write, critical, deferred, overflow, flag_was} and irq outputs
  logic [4:0]  ev_a [10] = '{5'h08, 5'h14, 5'h04, 5'h12, 5'h13,
                             5'h08, 5'h04, 5'h14, 5'h02, 5'h12};
  logic [3:0]  ex_a [10] = '{4'h8, 4'h2, 4'h0, 4'h1, 4'h0,
                             4'h4, 4'h2, 4'h0, 4'h1, 4'h0};

  error_record_addr_ctrl i_dut (
    .clock_i(clock_i), .rst_i(rst_i), .ce_i(ce_i), .mm_req_i(mm_req_i),
    .mm_write_i(mm_write_i), .mm_addr_i(mm_addr_i), .mm_wdata_i(mm_wdata_i),
    .mm_ack_o(mm_ack_o), .sel_write_i(sel_write_i),
    .sel_value_i(sel_value_i), .sel_value_o(sel_value_o),
    .sys_req_i(sys_req_i), .sys_write_i(sys_write_i),
    .sys_kind_i(sys_kind_i), .sys_wdata_i(sys_wdata_i),
    .sys_ack_o(sys_ack_o), .rdata_o(rdata_o), .cap_valid_i(cap_valid_i),
    .cap_idx_i(cap_idx_i), .cap_paddr_i(cap_paddr_i), .cap_ns_i(cap_ns_i),
    .cap_nse_i(cap_nse_i), .cap_unsure_i(cap_unsure_i),
    .cap_incorrect_i(cap_incorrect_i), .cap_va_i(cap_va_i),
    .status_av_i(status_av_i), .inj_av_i(inj_av_i),
    .evt_write_i(evt_write_i), .evt_critical_i(evt_critical_i),
    .evt_deferred_i(evt_deferred_i), .cnt_overflow_i(cnt_overflow_i),
    .ovf_flag_was_i(ovf_flag_was_i), .clr_crit_i(clr_crit_i),
    .clr_recov_i(clr_recov_i), .clr_fault_i(clr_fault_i),
    .crit_irq_o(crit_irq_o), .uncontained_o(uncontained_o),
    .recov_irq_o(recov_irq_o), .fault_irq_o(fault_irq_o));

  // All four interrupt levels in one word for compares
  assign irq_v = {crit_irq_o, uncontained_o, recov_irq_o, fault_irq_o};

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clock_i = 1'h0;
    forever #5 clock_i = ~clock_i;
  end

  // Xorshift source, fixed start so runs repeat
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Request held up across calls so back-to-back never re-drives an edge
  task automatic mm(input logic wr, input logic rec, input logic [5:0] ofs,
                    input word_t dat, input word_t ex);
    sys_req_i = 1'h0;
    {mm_req_i, mm_write_i, mm_addr_i, mm_wdata_i} = {1'h1, wr, rec, ofs, dat};
    exp_q.push_back(wr ? 64'h0 : ex);
    @(negedge clock_i);
  endtask

  task automatic sys_rd(input reg_kind_t k, input word_t ex);
    {mm_req_i, sys_req_i, sys_write_i} = {1'h0, 1'h1, 1'h0};
    sys_kind_i = k;
    exp_q.push_back(ex);
    @(negedge clock_i);
  endtask

  // Release requests, then wait a bounded time for every answer
  task automatic drain(input string nm);
    int n;
    mm_req_i = 1'h0;
    sys_req_i = 1'h0;
    for (n = 0; n < 20 && exp_q.size() != 0; n++) @(posedge clock_i);
    if (exp_q.size() != 0) begin
      mismatches++;
      $display("[FAIL] %s expected ack seen none", nm);
      stop_test();
    end
    @(negedge clock_i);
    $display("test %s done", nm);
  endtask

  // One event, irq check a cycle later, then clear all and check low
  task automatic ev(input logic [4:0] e, input logic [3:0] ex);
    {evt_write_i, evt_critical_i, evt_deferred_i, cnt_overflow_i,
     ovf_flag_was_i} = e;
    @(negedge clock_i);
    {evt_critical_i, evt_deferred_i, cnt_overflow_i} = 3'h0;
    `CHK("irqs", ex, irq_v)
    {clr_crit_i, clr_recov_i, clr_fault_i} = 3'h7;
    @(negedge clock_i);
    {clr_crit_i, clr_recov_i, clr_fault_i} = 3'h0;
    `CHK("irqs_clr", 4'h0, irq_v)
  endtask

  // every answer pairs with oldest note
  always @(negedge clock_i) begin
    if (mm_ack_o === 1'h1 || sys_ack_o === 1'h1) begin
      if (exp_q.size() == 0) begin
        mismatches++;
        $display("[FAIL] ack expected none seen %h", rdata_o);
      end else begin
        exp_w = exp_q.pop_front();
        `CHK("rdata", exp_w, rdata_o)
      end
    end
  end

  // Hang guard
  initial begin
    repeat (5000) @(posedge clock_i);
    mismatches++;
    $display("[FAIL] run expected finish seen hang");
    stop_test();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_i, ce_i, mm_req_i, mm_write_i, sys_req_i, sys_write_i} = 6'h30;
    {sel_write_i, cap_valid_i, cap_ns_i, cap_nse_i, cap_unsure_i} = 5'h0;
    {cap_incorrect_i, cap_va_i, inj_av_i, evt_write_i} = 4'h0;
    {evt_critical_i, evt_deferred_i, cnt_overflow_i, ovf_flag_was_i} = 4'h0;
    {clr_crit_i, clr_recov_i, clr_fault_i} = 3'h0;
    {mm_addr_i, sel_value_i, cap_idx_i, status_av_i} = 11'h0;
    {mm_wdata_i, sys_wdata_i, cap_paddr_i} = '0;
    sys_kind_i = REG_NONE;
    amask = 64'hF0FF_FFFF_FFFF_FFFF;
    repeat (4) @(negedge clock_i);
    rst_i = 1'h0;
    mm(1'h0, 1'h0, `CTRL_OFS, 64'h0, 64'h0);
    mm(1'h0, 1'h0, `ADDR_OFS, 64'h0, 64'h0);
    drain("reset");
    // reserved bits, second record, unmapped place
    d = {rnd(), rnd()};
    mm(1'h1, 1'h0, `CTRL_OFS, d, 64'h0);
    mm(1'h0, 1'h0, `CTRL_OFS, 64'h0, d & 64'h2F00);
    sys_rd(REG_CTRL, d & 64'h2F00);
    mm(1'h1, 1'h1, `CTRL_OFS, d, 64'h0);
    mm(1'h0, 1'h1, `CTRL_OFS, 64'h0, 64'h0);
    mm(1'h0, 1'h0, 6'h10, 64'h0, 64'h0);
    drain("control");
    d = {rnd(), rnd()};
    mm(1'h1, 1'h0, `ADDR_OFS, d, 64'h0);
    mm(1'h0, 1'h0, `ADDR_OFS, 64'h0, d & amask);
    status_av_i = 2'h1;
    mm(1'h1, 1'h0, `ADDR_OFS, ~d, 64'h0);
    mm(1'h0, 1'h0, `ADDR_OFS, 64'h0, d & amask);
    drain("location");
    status_av_i = 2'h0;
    // Enable low: a held read must be taken exactly once
    ce_i = 1'h0;
    mm(1'h0, 1'h0, `ADDR_OFS, 64'h0, d & amask);
    repeat (3) @(negedge clock_i);
    ce_i = 1'h1;
    @(negedge clock_i);
    drain("enable");
    // physical capture read through selected view, virtual capture read through mapped view
    d = {rnd(), rnd()};
    {cap_valid_i, cap_idx_i, cap_paddr_i} = {2'h3, d[55:0]};
    {cap_ns_i, cap_nse_i, cap_unsure_i, cap_incorrect_i, cap_va_i} = 5'h1C;
    {sel_write_i, sel_value_i} = 2'h3;
    @(negedge clock_i);
    {cap_valid_i, sel_write_i} = 2'h0;
    `CHK("select", 1'h1, sel_value_o)
    sys_rd(REG_ADDR, {8'hC0, d[55:0]});
    {cap_valid_i, cap_idx_i} = 2'h2;
    {cap_ns_i, cap_nse_i, cap_unsure_i, cap_incorrect_i, cap_va_i} = 5'h19;
    sys_req_i = 1'h0;
    @(negedge clock_i);
    cap_valid_i = 1'h0;
    mm(1'h0, 1'h0, `ADDR_OFS, 64'h0, {8'h70, d[55:0]});
    drain("capture");
    for (int i = 0; i < 10; i++) begin
      if (i == 0 || i == 5) begin
        mm(1'h1, 1'h0, `CTRL_OFS, (i == 0) ? 64'h2A00 : 64'h0500, 64'h0);
        drain("enables");
      end
      ev(ev_a[i], ex_a[i]);
    end
    $display("test interrupts done");
    stop_test();
  end
endmodule
